// *** verilog/vie_map.vh ***
// Constants for the vectored interrupt controller: register offsets, reset values, vector layout.
// Assumes a plain byte-addressed register port and a core that fetches vectors from memory.
// Overview of operation
// - Writing one to an enable-set bit enables that interrupt, to an enable-clear bit disables it, zeros do nothing.
// - Reading enable-set or enable-clear returns the present enable state, one bit per interrupt.
// - A request on a disabled interrupt makes it pending but not active until the interrupt is enabled.
// - An active interrupt that is disabled stays active until reset or exception return.
// - A cleared enable bit blocks every new activation until the interrupt is enabled again.
// - Writing one to a pending-set bit pends that interrupt, to a pending-clear bit unpends it, zeros do nothing.
// - Reading pending-set or pending-clear returns the present pending state.
// - A pending-clear write never changes the active state of an active interrupt.
// - Each interrupt has an 8-bit priority, four packed into each 32-bit priority register.
// - Enable, pending and priority registers sit in one memory-mapped block.
// - Vector table word 0 holds the initial main stack pointer loaded at reset.
// - Vector table word n holds the handler address for exception vector number n.
// - The vector table base is fixed at address zero and cannot be moved.
// - On taking an interrupt the handler address is fetched from the table with no software help.
`ifndef VIE_MAP_VH
`define VIE_MAP_VH
`define VIE_OFF_ISER      8'h00
`define VIE_OFF_ICER      8'h04
`define VIE_OFF_ISPR      8'h08
`define VIE_OFF_ICPR      8'h0c
`define VIE_OFF_IABR      8'h10
`define VIE_OFF_IRQ_STAT  8'h14
`define VIE_OFF_IRQ_MASK  8'h18
`define VIE_OFF_PRI_BASE  8'h20
`define VIE_PRI_W         8
`define VIE_RST_WORD      32'h00000000
`define VIE_VTOR_BASE     32'h00000000
`define VIE_VEC_SP_INDEX  6'h00
`define VIE_VEC_IRQ_FIRST 6'h10
`define VIE_EV_ACCEPT     0
`define VIE_EV_RETURN     1
`define VIE_EV_DROP       2
`endif

// *** verilog/vie_vector_mem.v ***
// Small vector table memory: word 0 holds the initial stack pointer, word n the handler of vector n.
// Assumes software or a loader writes the words before the core takes any exception.
`timescale 1ns/1ps
module vie_vector_mem #(
   parameter DEPTH = 48,
   parameter AW    = 6
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [31:0]   wdata,
   input  wire [AW-1:0] raddr,
   output reg  [31:0]   rdata_q
);
   reg [31:0] mem [0:DEPTH-1];

   // Read data come out of a register so the fetch is a clean one-cycle access.
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule

// *** verilog/vie_prio_pick.v ***
// Combinational arbiter: lowest priority value among candidates wins, lowest index on ties.
// Assumes priorities arrive packed eight bits per interrupt.
`timescale 1ns/1ps
module vie_prio_pick #(
   parameter N  = 32,
   parameter IW = 5
) (
   input  wire [N-1:0]   cand,
   input  wire [8*N-1:0] prio,
   output reg            found,
   output reg  [IW-1:0]  idx,
   output reg  [7:0]     best
);
   integer i;

   always @* begin
      found = 1'b0;
      idx   = {IW{1'b0}};
      best  = 8'hff;
      for (i = 0; i < N; i = i + 1) begin
         // Strict compare keeps the lower index on equal priority.
         if (cand[i] && (!found || prio[8*i +: 8] < best)) begin
            found = 1'b1;
            idx   = i[IW-1:0];
            best  = prio[8*i +: 8];
         end
      end
   end
endmodule

// *** verilog/vie_ctrl.v ***
// Vectored interrupt controller: enable, pending, active and priority state per interrupt,
// register port, core handshake and vector fetch.
// Assumes request lines and the register port are synchronous to clk; the core answers
// irq_req with irq_ack and signals exception return with exc_return.
`timescale 1ns/1ps
`include "vie_map.vh"
module vie_ctrl #(
   parameter N  = 32,
   parameter IW = 5,
   parameter VD = 48,
   parameter VW = 6
) (
   input  wire          clk,
   input  wire          sys_rst,
   input  wire [7:0]    reg_addr,
   input  wire [31:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [31:0]   reg_rdata_q,
   input  wire [N-1:0]  irq_lines,
   output reg           irq_req_q,
   output reg  [IW-1:0] irq_num_q,
   output reg  [7:0]    irq_prio_q,
   input  wire          irq_ack,
   input  wire          exc_return,
   input  wire [IW-1:0] exc_return_num,
   input  wire          vec_fetch,
   input  wire [VW-1:0] vec_num,
   output reg           vec_valid_q,
   output reg  [31:0]   vec_addr_q,
   output reg  [31:0]   vec_table_base_q,
   input  wire          vec_wr,
   input  wire [VW-1:0] vec_wr_num,
   input  wire [31:0]   vec_wr_data,
   output reg           int_out_q
);
   localparam NPR = (N + 3) / 4;

   reg  [N-1:0]   enable_q;
   reg  [N-1:0]   pending_q;
   reg  [N-1:0]   active_q;
   reg  [8*N-1:0] prio_q;
   reg  [2:0]     stat_q;
   reg  [2:0]     mask_q;
   reg  [N-1:0]   lines_q;
   reg            fetch_q;
   reg  [N-1:0]   enable_d;
   reg  [N-1:0]   pending_d;
   reg  [N-1:0]   active_d;
   reg  [2:0]     stat_d;
   reg  [31:0]    rdata_d;
   reg  [N-1:0]   ack_bit;
   reg  [N-1:0]   ret_bit;
   reg  [N-1:0]   wmask;
   reg            drop_ev;
   reg            take_ok;
   wire           found;
   wire [IW-1:0]  win_idx;
   wire [7:0]     win_prio;
   wire [31:0]    vec_rdata;
   wire [N-1:0]   rise;
   integer        k;
   integer        j;

   // Only a rising request pends; a held level would otherwise re-pend after activation.
   assign rise = irq_lines & ~lines_q;

   function [N-1:0] low_word;
      input [31:0] w;
      begin
         low_word = w[N-1:0];
      end
   endfunction

   function is_pri_addr;
      input [7:0] a;
      begin
         is_pri_addr = (a >= `VIE_OFF_PRI_BASE) && (a < `VIE_OFF_PRI_BASE + 4 * NPR);
      end
   endfunction

   vie_prio_pick #(.N(N), .IW(IW)) u_pick (
      .cand  (enable_q & pending_q & ~active_q),
      .prio  (prio_q),
      .found (found),
      .idx   (win_idx),
      .best  (win_prio)
   );

   vie_vector_mem #(.DEPTH(VD), .AW(VW)) u_vec (
      .clk     (clk),
      .we      (vec_wr),
      .waddr   (vec_wr_num),
      .wdata   (vec_wr_data),
      .raddr   (vec_num),
      .rdata_q (vec_rdata)
   );

   always @* begin
      wmask   = reg_wr ? low_word(reg_wdata) : {N{1'b0}};
      ack_bit = {N{1'b0}};
      ret_bit = {N{1'b0}};
      if (exc_return) begin
         ret_bit[exc_return_num] = 1'b1;
      end
      enable_d = enable_q;
      if (reg_addr == `VIE_OFF_ISER) begin
         enable_d = enable_q | wmask;
      end else if (reg_addr == `VIE_OFF_ICER) begin
         enable_d = enable_q & ~wmask;
      end
      // The offer is one cycle old, so an acknowledge can cross a disable or a pending
      // clear; such an acknowledge is refused rather than activating a disabled interrupt.
      take_ok = irq_ack && irq_req_q && enable_d[irq_num_q] && pending_q[irq_num_q];
      if (take_ok) begin
         ack_bit[irq_num_q] = 1'b1;
      end
      pending_d = pending_q;
      if (reg_addr == `VIE_OFF_ISPR) begin
         pending_d = pending_q | wmask;
      end else if (reg_addr == `VIE_OFF_ICPR) begin
         pending_d = pending_q & ~wmask;
      end
      // A new edge beats a clear in the same cycle; activation consumes the pending bit.
      pending_d = (pending_d | rise) & ~ack_bit;
      // Pending-clear never touches active; only return or reset ends activation.
      active_d = (active_q | ack_bit) & ~ret_bit;
      drop_ev = irq_req_q && !take_ok && !enable_d[irq_num_q];
      stat_d = stat_q;
      if (reg_wr && reg_addr == `VIE_OFF_IRQ_STAT) begin
         stat_d = stat_q & ~reg_wdata[2:0];
      end
      stat_d[`VIE_EV_ACCEPT] = stat_d[`VIE_EV_ACCEPT] | take_ok;
      stat_d[`VIE_EV_RETURN] = stat_d[`VIE_EV_RETURN] | exc_return;
      stat_d[`VIE_EV_DROP]   = stat_d[`VIE_EV_DROP] | drop_ev;
      rdata_d = `VIE_RST_WORD;
      case (reg_addr)
         `VIE_OFF_ISER, `VIE_OFF_ICER: rdata_d[N-1:0] = enable_q;
         `VIE_OFF_ISPR, `VIE_OFF_ICPR: rdata_d[N-1:0] = pending_q;
         `VIE_OFF_IABR:               rdata_d[N-1:0] = active_q;
         `VIE_OFF_IRQ_STAT:           rdata_d[2:0]   = stat_q;
         `VIE_OFF_IRQ_MASK:           rdata_d[2:0]   = mask_q;
         default: begin
            if (is_pri_addr(reg_addr)) begin
               for (k = 0; k < 4; k = k + 1) begin
                  if (4 * (reg_addr[7:2] - 6'h08) + k < N) begin
                     rdata_d[8*k +: 8] = prio_q[8 * (4 * (reg_addr[7:2] - 6'h08) + k) +: 8];
                  end
               end
            end
         end
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q         <= {N{1'b0}};
         pending_q        <= {N{1'b0}};
         active_q         <= {N{1'b0}};
         prio_q           <= {8*N{1'b0}};
         stat_q           <= 3'h0;
         mask_q           <= 3'h0;
         lines_q          <= {N{1'b0}};
         reg_rdata_q      <= 32'h00000000;
         irq_req_q        <= 1'b0;
         irq_num_q        <= {IW{1'b0}};
         irq_prio_q       <= 8'h00;
         fetch_q          <= 1'b0;
         vec_valid_q      <= 1'b0;
         vec_addr_q       <= 32'h00000000;
         vec_table_base_q <= `VIE_VTOR_BASE;
         int_out_q        <= 1'b0;
      end else begin
         enable_q    <= enable_d;
         pending_q   <= pending_d;
         active_q    <= active_d;
         stat_q      <= stat_d;
         lines_q     <= irq_lines;
         reg_rdata_q <= reg_rd ? rdata_d : 32'h00000000;
         if (reg_wr && reg_addr == `VIE_OFF_IRQ_MASK) begin
            mask_q <= reg_wdata[2:0];
         end
         if (reg_wr && is_pri_addr(reg_addr)) begin
            for (j = 0; j < 4; j = j + 1) begin
               if (4 * (reg_addr[7:2] - 6'h08) + j < N) begin
                  prio_q[8 * (4 * (reg_addr[7:2] - 6'h08) + j) +: 8] <= reg_wdata[8*j +: 8];
               end
            end
         end
         // Request is recomputed each cycle from the registered state, so a disable
         // withdraws it one cycle later; take_ok covers the cycle in between.
         irq_req_q  <= found && !(irq_ack && irq_req_q) && !exc_return;
         irq_num_q  <= win_idx;
         irq_prio_q <= win_prio;
         fetch_q    <= vec_fetch;
         vec_valid_q <= fetch_q;
         if (fetch_q) begin
            vec_addr_q <= vec_rdata;
         end
         int_out_q <= |(stat_d & mask_q);
      end
   end
endmodule

// *** test/vie_ctrl_props.sv ***
// Port assertions for the interrupt controller: read timing, enables, handshake, vectors.
// Assumes it is bound to vie_ctrl on one clock with an active-high asynchronous reset.
`timescale 1ns/1ps
`include "vie_map.vh"
module vie_ctrl_props (
   input wire        clk,
   input wire        sys_rst,
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata_q,
   input wire        irq_req_q,
   input wire        irq_ack,
   input wire        vec_fetch,
   input wire        vec_valid_q,
   input wire [31:0] vec_table_base_q,
   input wire        int_out_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire w_set = reg_wr && reg_addr == `VIE_OFF_ISER;
   wire w_clr = reg_wr && reg_addr == `VIE_OFF_ICER;
   wire r_en  = reg_rd && (reg_addr == `VIE_OFF_ISER || reg_addr == `VIE_OFF_ICER);
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data not zero outside read slot");
   en_set_a: assert property (
      w_set ##1 r_en |=> (reg_rdata_q & $past(reg_wdata, 2)) == $past(reg_wdata, 2))
      else $error("enable bits not set");
   en_clr_a: assert property (
      w_clr ##1 r_en |=> (reg_rdata_q & $past(reg_wdata, 2)) == 32'h0)
      else $error("enable bits not cleared");
   dis_req_a: assert property (w_clr && reg_wdata == 32'hffffffff |-> ##2 !irq_req_q)
      else $error("request offered after disable");
   ack_drop_a: assert property (irq_ack && irq_req_q |=> !irq_req_q)
      else $error("request held after acceptance");
   vec_lat_a: assert property (vec_fetch |-> ##2 vec_valid_q)
      else $error("vector not delivered in two cycles");
   vec_cause_a: assert property (vec_valid_q |-> $past(vec_fetch, 2))
      else $error("vector valid without fetch");
   base_zero_a: assert property (vec_table_base_q == 32'h0)
      else $error("vector base not zero");
   rst_clear_a: assert property (
      $past(sys_rst) |-> reg_rdata_q == 32'h0 && !irq_req_q && !int_out_q)
      else $error("outputs not clear after reset");
   mask_off_a: assert property (
      reg_wr && reg_addr == `VIE_OFF_IRQ_MASK && reg_wdata == 32'h0 |-> ##2 !int_out_q)
      else $error("interrupt output high with all masked");
   cover property (irq_ack && irq_req_q);
   cover property (vec_valid_q);
   cover property (int_out_q);
endmodule

// *** test/vie_core_model.sv ***
// Core model: accepts offered interrupts after a chosen wait and fetches their vectors.
// Assumes the handshake where irq_ack counts only while irq_req_q is high.
`timescale 1ns/1ps
`include "vie_map.vh"
module vie_core_model (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       take,
   input  wire [3:0] lat,
   input  wire       boot,
   input  wire       ret,
   input  wire       irq_req_q,
   input  wire [4:0] irq_num_q,
   output reg        irq_ack,
   output reg        exc_return,
   output reg  [4:0] exc_return_num,
   output reg        vec_fetch,
   output reg  [5:0] vec_num
);
   reg  [3:0] wait_q;
   // The ack just sent blocks a second one while the request is still seen high.
   wire       acc = take && irq_req_q && !irq_ack && wait_q >= lat;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ack        <= 1'b0;
         exc_return     <= 1'b0;
         exc_return_num <= 5'h00;
         vec_fetch      <= 1'b0;
         vec_num        <= 6'h00;
         wait_q         <= 4'h0;
      end else begin
         wait_q     <= (irq_req_q && !irq_ack) ? wait_q + 4'h1 : 4'h0;
         irq_ack    <= acc;
         exc_return <= ret;
         vec_fetch  <= boot || acc;
         vec_num    <= boot ? `VIE_VEC_SP_INDEX : {1'b0, irq_num_q} + `VIE_VEC_IRQ_FIRST;
         if (acc) begin
            exc_return_num <= irq_num_q;
         end
      end
   end
endmodule

// *** test/vie_ctrl_tb.sv ***
// Self-checking bench for vie_ctrl with the core model on its far side.
// Assumes the design files and vie_map.vh are on the include path.
`timescale 1ns/1ps
`include "vie_map.vh"
module vie_ctrl_tb;
   reg         clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [31:0] reg_wdata = 32'h0, irq_lines = 32'h0, vec_wr_data = 32'h0;
   reg         vec_wr = 1'b0, take = 1'b0, boot = 1'b0, ret = 1'b0;
   reg  [5:0]  vec_wr_num = 6'h0, vn1, vn2;
   reg  [3:0]  lat = 4'h3;
   wire [31:0] reg_rdata_q, vec_addr_q, vec_table_base_q;
   wire [4:0]  irq_num_q, exc_return_num;
   wire [7:0]  irq_prio_q;
   wire [5:0]  vec_num;
   wire        irq_req_q, irq_ack, exc_return, vec_fetch, vec_valid_q, int_out_q;
   reg  [31:0] vtab [0:47];
   reg  [31:0] rs = 32'h15, en, pn, v, w;
   integer     errors = 0, num_checks = 0, cyc = 0, i;
   always #2.5 clk = ~clk;
   vie_ctrl vie_ctrl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .irq_lines(irq_lines), .irq_req_q(irq_req_q), .irq_num_q(irq_num_q),
      .irq_prio_q(irq_prio_q), .irq_ack(irq_ack), .exc_return(exc_return),
      .exc_return_num(exc_return_num), .vec_fetch(vec_fetch), .vec_num(vec_num),
      .vec_valid_q(vec_valid_q), .vec_addr_q(vec_addr_q), .vec_table_base_q(vec_table_base_q),
      .vec_wr(vec_wr), .vec_wr_num(vec_wr_num), .vec_wr_data(vec_wr_data), .int_out_q(int_out_q));
   vie_core_model vie_core_model_i (.clk(clk), .sys_rst(sys_rst), .take(take), .lat(lat),
      .boot(boot), .ret(ret), .irq_req_q(irq_req_q), .irq_num_q(irq_num_q), .irq_ack(irq_ack),
      .exc_return(exc_return), .exc_return_num(exc_return_num), .vec_fetch(vec_fetch),
      .vec_num(vec_num));
   function [31:0] xs();
      begin
         rs = rs ^ (rs << 13);
         rs = rs ^ (rs >> 17);
         rs = rs ^ (rs << 5);
         xs = rs;
      end
   endfunction
   function [31:0] upd(input [31:0] cur, input [31:0] s, input [31:0] c);
      upd = (cur | s) & ~c;
   endfunction
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("BAD %s exp %h got %h", n, e, s);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         reg_addr  <= a;
         reg_wdata <= d;
         reg_rd    <= 1'b0;
         reg_wr    <= 1'b1;
         @(posedge clk);
      end
   endtask
   // Strobes are lowered by the next task, so back-to-back writes never assign twice.
   task idle(input integer n);
      begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         repeat (n) @(posedge clk);
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         reg_addr <= a;
         reg_wr   <= 1'b0;
         reg_rd   <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(posedge clk);
         chk("reg_rdata", reg_rdata_q, e);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Vector answers arrive two cycles after the fetch, so the number is delayed to match.
   always @(posedge clk) begin
      vn1 <= vec_num;
      vn2 <= vn1;
      cyc <= cyc + 1;
      if (vec_valid_q === 1'b1) chk("vec_addr", vec_addr_q, vtab[vn2]);
      if (cyc == 3000) begin
         errors = errors + 1;
         final_report;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("vec_base", vec_table_base_q, `VIE_VTOR_BASE);
      for (i = 0; i < 32; i = i + 1) rd({i[5:0], 2'b00}, 32'h0);
      for (i = 0; i < 48; i = i + 1) begin
         vtab[i] = xs();
         vec_wr      <= 1'b1;
         vec_wr_num  <= i[5:0];
         vec_wr_data <= vtab[i];
         @(posedge clk);
      end
      vec_wr <= 1'b0;
      boot   <= 1'b1;
      @(posedge clk);
      boot <= 1'b0;
      en = 32'h0;
      pn = 32'h0;
      for (i = 0; i < 8; i = i + 1) begin
         v = xs();
         w = xs();
         en = upd(en, v, 32'h0);
         wr(`VIE_OFF_ISER, v);
         rd(`VIE_OFF_ICER, en);
         en = upd(en, 32'h0, w);
         wr(`VIE_OFF_ICER, w);
         rd(`VIE_OFF_ISER, en);
         pn = upd(pn, w, 32'h0);
         wr(`VIE_OFF_ISPR, w);
         rd(`VIE_OFF_ICPR, pn);
         pn = upd(pn, 32'h0, v);
         wr(`VIE_OFF_ICPR, v);
         rd(`VIE_OFF_ISPR, pn);
         wr(`VIE_OFF_PRI_BASE + {3'h0, i[2:0], 2'b00}, v);
         rd(`VIE_OFF_PRI_BASE + {3'h0, i[2:0], 2'b00}, v);
      end
      wr(`VIE_OFF_ICER, 32'hffffffff);
      wr(`VIE_OFF_ICPR, 32'hffffffff);
      wr(`VIE_OFF_IRQ_STAT, 32'hffffffff);
      wr(`VIE_OFF_PRI_BASE + 8'h08, 32'h00004080);
      wr(`VIE_OFF_ISPR, 32'h00000300);
      wr(`VIE_OFF_ISER, 32'h00000300);
      idle(3);
      chk("irq_num", {27'h0, irq_num_q}, 32'h9);
      chk("irq_prio", {24'h0, irq_prio_q}, 32'h40);
      wr(`VIE_OFF_IRQ_MASK, 32'h00000007);
      take <= 1'b1;
      idle(14);
      rd(`VIE_OFF_IABR, 32'h00000300);
      rd(`VIE_OFF_ISPR, 32'h0);
      rd(`VIE_OFF_IRQ_STAT, 32'h00000001);
      chk("int_out", {31'h0, int_out_q}, 32'h1);
      wr(`VIE_OFF_ICER, 32'h00000300);
      rd(`VIE_OFF_IABR, 32'h00000300);
      wr(`VIE_OFF_ICPR, 32'h00000300);
      rd(`VIE_OFF_IABR, 32'h00000300);
      irq_lines <= 32'h00000020;
      idle(4);
      rd(`VIE_OFF_ISPR, 32'h00000020);
      rd(`VIE_OFF_IABR, 32'h00000300);
      lat <= 4'h0;
      wr(`VIE_OFF_ISER, 32'h00000020);
      idle(6);
      rd(`VIE_OFF_IABR, 32'h00000320);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      idle(3);
      rd(`VIE_OFF_IABR, 32'h00000300);
      rd(`VIE_OFF_IRQ_STAT, 32'h00000003);
      wr(`VIE_OFF_IRQ_STAT, 32'h00000003);
      wr(`VIE_OFF_IRQ_MASK, 32'h0);
      rd(`VIE_OFF_IRQ_STAT, 32'h0);
      chk("int_out", {31'h0, int_out_q}, 32'h0);
      final_report;
   end
endmodule
bind vie_ctrl vie_ctrl_props vie_ctrl_props_i (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q), .irq_req_q(irq_req_q), .irq_ack(irq_ack),
   .vec_fetch(vec_fetch), .vec_valid_q(vec_valid_q), .vec_table_base_q(vec_table_base_q),
   .int_out_q(int_out_q));
